// ### hw/brt_core.v
// brt_core.v: basic 16-bit reload timer with trigger filter and flip outputs
// assumes all control inputs are synchronous to i_clk, write strobes one cycle
`timescale 1ns/1ns
`include "brt_defs.vh"

module brt_core #(
   parameter W = 16
) (
   // clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // trigger sources
   input wire i_external_trigger_input,
   input wire i_internal_trigger_input,
   // configuration levels
   input wire [1:0] i_mode,
   input wire i_source_select_bit,
   input wire i_input_sense_select,
   input wire i_single_run_select,
   input wire i_flip_output_enable,
   input wire [2:0] i_external_filter_setting,
   input wire [W-1:0] i_prescale_value,
   // run enable write
   input wire i_run_wr,
   input wire i_run_wdata,
   // reload value write
   input wire i_reload_wr,
   input wire [W-1:0] i_reload_wdata,
   // flag clears
   input wire i_overflow_clr,
   input wire i_trigger_clr,
   // status
   output reg o_run_en,
   output reg [W-1:0] o_count_value,
   output reg [W-1:0] o_reload_value,
   output reg o_reload_wrap_pulse,
   output reg o_overflow_flag,
   output reg o_trigger_seen_flag,
   // flip output pins
   output reg o_flip_out_true,
   output reg o_flip_out_inverse
);

   localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   wire filt;
   wire divided_count_clock;
   wire src;
   wire sensed;
   wire gate_on;
   wire edge_seen;
   wire mode_count;
   wire mode_trig;
   wire mode_gate;
   wire trig_evt;
   wire os_end;
   wire step;
   wire pre_load;
   wire reload_low;

   reg sensed_r;
   reg os_r;
   reg phase_r;
   reg run_nxt;
   reg ovf_nxt;
   reg trig_nxt;
   reg phase_nxt;

   brt_filter u_filter (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_external_filter_setting(i_external_filter_setting),
      .i_external_trigger_input(i_external_trigger_input),
      .o_filtered(filt)
   );

   // mode decode
   assign mode_count = (i_mode == `BRT_MODE_COUNT);
   assign mode_trig = (i_mode == `BRT_MODE_TRIG);
   assign mode_gate = (i_mode == `BRT_MODE_GATE);

   // source choice and sense; xor maps sense 1 onto low level / falling edge
   assign src = i_source_select_bit ? i_internal_trigger_input : filt;
   assign sensed = src ^ i_input_sense_select;
   assign edge_seen = sensed & ~sensed_r;
   // the gate always comes from the external pin, whatever the source select
   assign gate_on = filt ^ i_input_sense_select;
   assign trig_evt = mode_trig & edge_seen;

   // one-shot end: the cycle in which the wrap pulse is high with os_r set
   assign os_end = o_reload_wrap_pulse & os_r;

   // prescaler input: counter mode counts source edges, gate mode counts clocks while the gate is on, the rest count clocks
   assign step = o_run_en & ~os_end &
                 (mode_count ? edge_seen : mode_gate ? gate_on : 1'b1);
   assign pre_load = (run_nxt & ~o_run_en) | o_reload_wrap_pulse;

   brt_prescale #(
      .W(W)
   ) u_prescale (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_prescale_value(i_prescale_value),
      .i_load(pre_load),
      .i_trig_src(mode_count),
      .i_clr(~o_run_en),
      .i_step(step),
      .o_divided_count_clock(divided_count_clock)
   );

   assign reload_low = i_reload_wdata < o_count_value;

   // run enable: hardware stop and trigger start override a software write
   always @* begin
      run_nxt = o_run_en;
      if (i_run_wr)
         run_nxt = i_run_wdata;
      if (os_end)
         run_nxt = 1'b0;
      if (trig_evt)
         run_nxt = 1'b1;
   end

   // sticky flags: a set in the clearing cycle wins
   always @* begin
      ovf_nxt = o_overflow_flag;
      if (i_overflow_clr)
         ovf_nxt = 1'b0;
      if (os_end)
         ovf_nxt = 1'b1;
      if (o_reload_wrap_pulse & ~os_r)
         ovf_nxt = 1'b1;
      trig_nxt = o_trigger_seen_flag;
      if (i_trigger_clr)
         trig_nxt = 1'b0;
      if (trig_evt)
         trig_nxt = 1'b1;
   end

   // flip phase rests high so enabling starts with the true output high
   always @* begin
      phase_nxt = phase_r;
      if (!i_flip_output_enable)
         phase_nxt = 1'b1;
      else if (o_reload_wrap_pulse)
         phase_nxt = ~phase_r;
   end

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sensed_r <= 1'b0;
         os_r <= 1'b0;
         phase_r <= 1'b1;
         o_run_en <= 1'b0;
         o_count_value <= `BRT_CNT_RST;
         o_reload_value <= `BRT_RELOAD_RST;
         o_reload_wrap_pulse <= 1'b0;
         o_overflow_flag <= 1'b0;
         o_trigger_seen_flag <= 1'b0;
         o_flip_out_true <= 1'b0;
         o_flip_out_inverse <= 1'b0;
      end else begin
         sensed_r <= sensed;
         o_run_en <= run_nxt;
         o_overflow_flag <= ovf_nxt;
         o_trigger_seen_flag <= trig_nxt;
         phase_r <= phase_nxt;
         o_reload_wrap_pulse <= 1'b0;
         if (i_reload_wr) begin
            o_reload_value <= i_reload_wdata;
            // a reload below the count restarts silently rather than wrapping
            if (reload_low)
               o_count_value <= `BRT_CNT_RST;
            else if (divided_count_clock & o_run_en & ~os_end)
               o_count_value <= o_count_value + ONE;
         end else if (divided_count_clock & o_run_en & ~os_end) begin
            if (o_count_value == o_reload_value) begin
               o_count_value <= `BRT_CNT_RST;
               o_reload_wrap_pulse <= 1'b1;
               os_r <= i_single_run_select;
            end else begin
               o_count_value <= o_count_value + ONE;
            end
         end
         // both outputs low when disabled, otherwise complementary
         o_flip_out_true <= i_flip_output_enable & phase_nxt;
         o_flip_out_inverse <= i_flip_output_enable & ~phase_nxt;
      end
   end

endmodule // brt_core

// ### hw/brt_filter.v
// brt_filter.v: synchroniser and sample-count filter for the external trigger
// assumes i_clk is the bus clock and the setting is held steady while in use
`timescale 1ns/1ns
`include "brt_defs.vh"

module brt_filter (
   // clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // configuration
   input wire [2:0] i_external_filter_setting,
   // pin in, filtered level out
   input wire i_external_trigger_input,
   output reg o_filtered
);

   // decode one setting into {divide exponent, sample count}
   function [5:0] brt_flt_decode;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: brt_flt_decode = `BRT_FLT_TAB1;
            3'h2: brt_flt_decode = `BRT_FLT_TAB2;
            3'h3: brt_flt_decode = `BRT_FLT_TAB3;
            3'h4: brt_flt_decode = `BRT_FLT_TAB4;
            3'h5: brt_flt_decode = `BRT_FLT_TAB5;
            3'h6: brt_flt_decode = `BRT_FLT_TAB6;
            3'h7: brt_flt_decode = `BRT_FLT_TAB7;
            default: brt_flt_decode = 6'h00;
         endcase
      end
   endfunction

   reg sync0_r;
   reg sync1_r;
   reg [2:0] div_r;
   reg last_r;
   reg [3:0] run_r;
   wire [5:0] tab;
   wire [3:0] need;
   wire [2:0] mask;
   wire tick;

   assign tab = brt_flt_decode(i_external_filter_setting);
   assign need = tab[3:0];
   assign mask = (tab[5:4] == 2'h0) ? 3'h0 : (tab[5:4] == 2'h1) ? 3'h1 :
                 (tab[5:4] == 2'h2) ? 3'h3 : 3'h7;
   // sample strobe is the bus clock divided by 2^exponent
   assign tick = ((div_r & mask) == mask);

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync0_r <= 1'b0;
         sync1_r <= 1'b0;
         div_r <= 3'h0;
         last_r <= 1'b0;
         run_r <= 4'h0;
         o_filtered <= 1'b0;
      end else begin
         // two-flop synchroniser before anything looks at the pin
         sync0_r <= i_external_trigger_input;
         sync1_r <= sync0_r;
         div_r <= div_r + 3'h1;
         if (i_external_filter_setting == `BRT_FLT_BYPASS) begin
            o_filtered <= sync1_r;
            last_r <= sync1_r;
            run_r <= 4'h0;
         end else if (tick) begin
            if (sync1_r != last_r) begin
               last_r <= sync1_r;
               run_r <= 4'h1;
            end else if (run_r < need) begin
               run_r <= run_r + 4'h1;
               // level is trusted only after N matching samples
               if (run_r + 4'h1 == need)
                  o_filtered <= last_r;
            end
         end
      end
   end

endmodule // brt_filter

// ### hw/brt_prescale.v
// brt_prescale.v: programmable prescaler producing the divided count clock pulse
// assumes i_step marks each source event, one cycle wide
`timescale 1ns/1ns
`include "brt_defs.vh"

module brt_prescale #(
   parameter W = 16
) (
   // clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // control
   input wire [W-1:0] i_prescale_value,
   input wire i_load,
   input wire i_trig_src,
   input wire i_clr,
   input wire i_step,
   // divided count clock pulse
   output reg o_divided_count_clock
);

   reg [W-1:0] act_r;
   reg [W-1:0] cnt_r;
   wire [W-1:0] term;

   // bus clock divides by value+1, trigger source by value (zero acts as one)
   assign term = !i_trig_src ? act_r :
                 (act_r == {W{1'b0}}) ? {W{1'b0}} : act_r - {{(W-1){1'b0}}, 1'b1};

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         act_r <= `BRT_PSC_RST;
         cnt_r <= {W{1'b0}};
         o_divided_count_clock <= 1'b0;
      end else begin
         o_divided_count_clock <= 1'b0;
         // new value only taken at overflow or at run start
         if (i_load)
            act_r <= i_prescale_value;
         // the count keeps its phase across a load, else each overflow would stretch the period
         if (i_clr) begin
            cnt_r <= {W{1'b0}};
         end else if (i_step) begin
            if (cnt_r >= term) begin
               cnt_r <= {W{1'b0}};
               o_divided_count_clock <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // brt_prescale

// ### pkg/brt_defs.vh
// brt_defs.vh: constants shared by the basic reload timer files
// assumes inclusion by bare name from every design file of the timer
`ifndef BRT_DEFS_VH
`define BRT_DEFS_VH

// operating mode codes
`define BRT_MODE_TIMER 2'h0
`define BRT_MODE_COUNT 2'h1
`define BRT_MODE_TRIG 2'h2
`define BRT_MODE_GATE 2'h3

// reset values
`define BRT_CNT_RST 16'h0000
`define BRT_RELOAD_RST 16'hFFFF
`define BRT_PSC_RST 16'h0000

// filter table entries: {sample divide exponent[1:0], sample count N[3:0]}
`define BRT_FLT_BYPASS 3'h0
`define BRT_FLT_TAB1 6'h02
`define BRT_FLT_TAB2 6'h04
`define BRT_FLT_TAB3 6'h06
`define BRT_FLT_TAB4 6'h24
`define BRT_FLT_TAB5 6'h26
`define BRT_FLT_TAB6 6'h36
`define BRT_FLT_TAB7 6'h38

`endif

// ### verification/brt_core_props.sv
// brt_core_props.sv: port-level checks of the reload timer core
// assumes one clock domain; bound onto every brt_core instance
`timescale 1ns/1ns
`include "brt_defs.vh"
module brt_core_props #(
   parameter W = 16
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [1:0] i_mode,
   input wire i_single_run_select,
   input wire i_flip_output_enable,
   input wire i_reload_wr,
   input wire [W-1:0] i_reload_wdata,
   input wire o_run_en,
   input wire [W-1:0] o_count_value,
   input wire [W-1:0] o_reload_value,
   input wire o_reload_wrap_pulse,
   input wire o_overflow_flag,
   input wire o_trigger_seen_flag,
   input wire o_flip_out_true,
   input wire o_flip_out_inverse
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_wrap_end;
      o_reload_wrap_pulse ##1 !o_reload_wrap_pulse;
   endsequence
   sequence s_stopped;
      !o_run_en && o_overflow_flag && o_count_value == 0;
   endsequence
   a_wrap_one_cycle: assert property ($rose(o_reload_wrap_pulse) |-> s_wrap_end)
      else $error("wrap pulse not one cycle");
   a_wrap_at_zero: assert property (o_reload_wrap_pulse |-> o_count_value == 0)
      else $error("wrap with nonzero count");
   a_wrap_sets_flag: assert property (o_reload_wrap_pulse |=> o_overflow_flag)
      else $error("overflow flag not set");
   a_single_run_select_stop: assert property (o_reload_wrap_pulse && i_single_run_select
      && i_mode != `BRT_MODE_TRIG |=> s_stopped) else $error("one-shot did not stop");
   a_flip_off_low: assert property (!i_flip_output_enable |=> !o_flip_out_true && !o_flip_out_inverse)
      else $error("flip outputs not low");
   a_flip_on_high: assert property ($rose(i_flip_output_enable) |=> o_flip_out_true && !o_flip_out_inverse)
      else $error("flip start level wrong");
   a_flip_swap: assert property (o_reload_wrap_pulse && i_flip_output_enable
      && $past(i_flip_output_enable) |=> o_flip_out_true != $past(o_flip_out_true)
      && o_flip_out_true != o_flip_out_inverse) else $error("flip outputs did not invert");
   a_reload_restart: assert property (i_reload_wr && i_reload_wdata < o_count_value
      |=> o_count_value == 0 && !o_reload_wrap_pulse && o_reload_value == $past(i_reload_wdata))
      else $error("reload below count mishandled");
   a_trig_runs: assert property ($rose(o_trigger_seen_flag) && i_mode == `BRT_MODE_TRIG |-> o_run_en)
      else $error("trigger did not start run");
endmodule // brt_core_props

bind brt_core brt_core_props #(.W(W)) u_props (.i_clk, .i_sys_rst, .i_mode, .i_single_run_select,
   .i_flip_output_enable, .i_reload_wr, .i_reload_wdata, .o_run_en, .o_count_value, .o_reload_value,
   .o_reload_wrap_pulse, .o_overflow_flag, .o_trigger_seen_flag, .o_flip_out_true, .o_flip_out_inverse);

// ### verification/brt_trig_model.sv
// brt_trig_model.sv: external trigger pin and internal trigger source
// assumes one bench process calls its tasks, one at a time
`timescale 1ns/1ns
module brt_trig_model (
   input wire i_clk,
   output logic o_ext,
   output logic o_int
);
   initial begin
      o_ext = 1'b0;
      o_int = 1'b0;
   end
   // levels move just after a rising edge; the pin is always driven
   task ext_pulse(input int n);
      @(posedge i_clk) o_ext <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_ext <= 1'b0;
   endtask
   task ext_set(input logic v);
      @(posedge i_clk) o_ext <= v;
   endtask
   task int_set(input logic v);
      @(posedge i_clk) o_int <= v;
   endtask
   task int_pulse;
      int_set(1'b1);
      repeat (2) @(posedge i_clk);
      o_int <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
endmodule // brt_trig_model

// ### verification/tb_brt_core.sv
// tb_brt_core.sv: directed tests of the reload timer through its control ports
// assumes brt_core at W=16, trigger model and bound checker alongside
`timescale 1ns/1ns
`include "brt_defs.vh"
module tb_brt_core;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [1:0] mode = `BRT_MODE_TIMER;
   logic src = 1'b0, sense = 1'b0, single = 1'b0, flip = 1'b0;
   logic [2:0] flt = 3'h0;
   logic [15:0] prescale_value = 16'h0000, rl_wd = 16'h0000, c0;
   logic run_wr = 1'b0, run_wd = 1'b0, rl_wr = 1'b0, ovf_clr = 1'b0, trg_clr = 1'b0, t;
   wire ext, internal_trigger_input, run_en, wrap, ovf, trg, ft, fi;
   wire [15:0] cnt, rel;
   int n_fail = 0, checks = 0;
   time t0;
   always #5 i_clk = ~i_clk;
   brt_trig_model m_trig (.i_clk(i_clk), .o_ext(ext), .o_int(internal_trigger_input));
   brt_core #(.W(16)) u_brt_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_external_trigger_input(ext),
      .i_internal_trigger_input(internal_trigger_input), .i_mode(mode), .i_source_select_bit(src), .i_input_sense_select(sense),
      .i_single_run_select(single), .i_flip_output_enable(flip), .i_external_filter_setting(flt),
      .i_prescale_value(prescale_value), .i_run_wr(run_wr), .i_run_wdata(run_wd), .i_reload_wr(rl_wr),
      .i_reload_wdata(rl_wd), .i_overflow_clr(ovf_clr), .i_trigger_clr(trg_clr), .o_run_en(run_en),
      .o_count_value(cnt), .o_reload_value(rel), .o_reload_wrap_pulse(wrap), .o_overflow_flag(ovf),
      .o_trigger_seen_flag(trg), .o_flip_out_true(ft), .o_flip_out_inverse(fi));
   task end_of_test;
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // k picks the strobe: 0 run, 1 reload, 2 overflow clear, 3 trigger clear
   task wr(input int k, input logic [15:0] v);
      @(posedge i_clk);
      run_wr <= (k == 0);
      rl_wr <= (k == 1);
      ovf_clr <= (k == 2);
      trg_clr <= (k == 3);
      run_wd <= v[0];
      rl_wd <= v;
      @(posedge i_clk);
      {run_wr, rl_wr, ovf_clr, trg_clr} <= 4'h0;
      #1;
   endtask
   // one call sets every configuration level at the same edge
   task cfg(input logic [1:0] m, input logic s, input logic p, input logic o, input logic f,
      input logic [2:0] fl, input logic [15:0] ps);
      @(posedge i_clk);
      mode <= m;
      src <= s;
      sense <= p;
      single <= o;
      flip <= f;
      flt <= fl;
      prescale_value <= ps;
   endtask
   task wwrap;
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (wrap !== 1'b1 && n < 400);
      if (wrap !== 1'b1) chk(wrap, 1'b1);
   endtask
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      tick(1);
      chk(cnt, 16'h0000);
      chk({run_en, ft, fi}, 3'h0);
      chk(rel, `BRT_RELOAD_RST);
      // timer, continuous: period (P+1)*(reload+1)
      cfg(`BRT_MODE_TIMER, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0002);
      wr(1, 16'h0003);
      wr(0, 16'h0001);
      wwrap;
      t0 = $time;
      t = ft;
      wr(2, 16'h0000);
      wwrap;
      chk(16'(($time - t0) / 10), 16'd12);
      chk({ft, fi}, {~t, t});
      chk(ovf, 1'b0);
      t0 = $time;
      tick(1);
      chk({ovf, run_en}, 2'h3);
      cfg(`BRT_MODE_TIMER, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0000);
      wwrap;
      chk(16'(($time - t0) / 10), 16'd12);
      wwrap;
      t0 = $time;
      wwrap;
      chk(16'(($time - t0) / 10), 16'd4);
      // reload below count, then one-shot
      wr(1, 16'hFFFF);
      cfg(`BRT_MODE_TIMER, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 16'h0000);
      wr(2, 16'h0000);
      tick(6);
      wr(1, 16'h0002);
      chk(cnt < 2, 1'b1);
      chk(rel, 16'h0002);
      wwrap;
      tick(3);
      chk({run_en, ovf, cnt}, {2'h1, 16'h0000});
      cfg(`BRT_MODE_TIMER, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 16'h0000);
      tick(2);
      chk({ft, fi}, 2'h0);
      cfg(`BRT_MODE_TIMER, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 16'h0000);
      tick(2);
      chk({ft, fi}, 2'h2);
      // trigger start from the filtered pin: 20 cycles is under six quarter-rate samples
      cfg(`BRT_MODE_TRIG, 1'b0, 1'b0, 1'b0, 1'b1, 3'h5, 16'h0000);
      wr(3, 16'h0000);
      m_trig.ext_pulse(20);
      tick(40);
      chk(trg, 1'b0);
      m_trig.ext_pulse(40);
      tick(2);
      chk({trg, run_en}, 2'h3);
      cfg(`BRT_MODE_TRIG, 1'b1, 1'b1, 1'b0, 1'b1, 3'h5, 16'h0000);
      tick(3);
      wr(0, 16'h0000);
      wr(3, 16'h0000);
      m_trig.int_set(1'b1);
      tick(4);
      chk(trg, 1'b0);
      m_trig.int_set(1'b0);
      tick(4);
      chk({trg, run_en}, 2'h3);
      // gated, active low
      cfg(`BRT_MODE_GATE, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0, 16'h0000);
      wr(1, 16'hFFFF);
      m_trig.ext_set(1'b1);
      tick(6);
      c0 = cnt;
      tick(10);
      chk(cnt, c0);
      m_trig.ext_set(1'b0);
      tick(10);
      chk(cnt > c0, 1'b1);
      // counter mode: four rising edges divided by two
      cfg(`BRT_MODE_COUNT, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0002);
      wr(0, 16'h0000);
      wr(0, 16'h0001);
      c0 = cnt;
      repeat (4) m_trig.int_pulse;
      tick(3);
      chk(cnt, c0 + 16'h0002);
      end_of_test;
   end
endmodule // tb_brt_core
